// ==== logic/wfcfc_consts.vh ====
// Constants shared by the waveform capture fill control block.
`ifndef WFCFC_CONSTS_VH
`define WFCFC_CONSTS_VH
// =====================================================================
// Buffer geometry
`define WFCFC_ADDR_FIRST   12'h800
`define WFCFC_ADDR_LAST    12'hFFF
`define WFCFC_PAGE_LSB     7
`define WFCFC_PAGE_MSB     10
`define WFCFC_PAGE_WORDS   7'h7F
`define WFCFC_SLOT_LAST    3'h7
`define WFCFC_SLOT_NEUTRAL 3'h6
`define WFCFC_CENTER_WORDS 11'h400
`define WFCFC_CENTER_MAX   12'hBFF
// =====================================================================
// Fill modes
`define WFCFC_MODE_FULL    2'h0
`define WFCFC_MODE_STOP    2'h1
`define WFCFC_MODE_CENTER  2'h2
`define WFCFC_MODE_SAVE    2'h3
// =====================================================================
// Trigger enable map
`define WFCFC_TRG_FORCE    10
`define WFCFC_TRG_WIDTH    11
// =====================================================================
// Status bits and reset values
`define WFCFC_ST_PAGE      0
`define WFCFC_ST_TRIG      1
`define WFCFC_ST_STOP      2
`define WFCFC_ZERO16       16'h0000
`define WFCFC_ZERO12       12'h000
`define WFCFC_ZERO4        4'h0
`endif

// ==== logic/wfcfc_addr_gen.v ====
// Write address generator for the circular capture memory.
`timescale 1ns/1ns
module wfcfc_addr_gen (
	// Clock and reset.
	input  wire        clk_in,
	input  wire        reset_n_in,
	// Control.
	input  wire        restart_in,
	input  wire        advance_in,
	// Current address.
	output reg  [11:0] addr_out
);
`include "wfcfc_consts.vh"
	// =====================================================================
	// Pointer
	// The pointer returns to the first word on restart and wraps after the last.
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_out <= `WFCFC_ADDR_FIRST;
		end else if (restart_in) begin
			addr_out <= `WFCFC_ADDR_FIRST;
		end else if (advance_in) begin
			if (addr_out == `WFCFC_ADDR_LAST) begin
				addr_out <= `WFCFC_ADDR_FIRST;
			end else begin
				addr_out <= addr_out + 12'h001;
			end
		end
	end
endmodule // wfcfc_addr_gen

// ==== logic/wfcfc_top.v ====
// Fill and trigger control of the circular waveform capture memory.
`timescale 1ns/1ns
module wfcfc_top #(
	parameter DATA_W = 32
) (
	// Clock and reset.
	input  wire              CLOCK_IN,
	input  wire              RESET_N_IN,
	// Configuration from the host register file.
	input  wire              CAPTURE_SOURCE_SELECT_IN,
	input  wire [1:0]        FILL_MODE_FIELD_IN,
	input  wire              CAPTURE_ENABLE_BIT_IN,
	input  wire [15:0]       TRIGGER_ENABLE_MASK_IN,
	input  wire [15:0]       PAGE_MASK_IN,
	input  wire [2:0]        IRQ_ENABLE_IN,
	input  wire [2:0]        STATUS_CLEAR_IN,
	// Interrupt events from the device, one per trigger source bit 9..0.
	input  wire [9:0]        EVENT_IN,
	// Sample stream: seven channels per set, one word per strobe.
	input  wire              SAMPLE_VALID_IN,
	input  wire [DATA_W-1:0] SAMPLE_DATA_IN,
	// Memory write port.
	output reg               MEM_WE_OUT,
	output reg  [11:0]       MEM_ADDR_OUT,
	output reg  [DATA_W-1:0] MEM_DATA_OUT,
	// Status to the host.
	output reg  [2:0]        EVENT_STATUS_WORD_OUT,
	output reg  [3:0]        LAST_FILLED_PAGE_OUT,
	output reg  [11:0]       TRIGGER_ADDRESS_FIELD_OUT,
	output reg               FILLING_OUT,
	output reg               EVENT_IRQ_LINE_OUT
);
`include "wfcfc_consts.vh"
	// =====================================================================
	// Input synchronisers
	// Events and stream come from other logic on this clock; host register bits
	// are from this clock too, so no synchroniser stage is needed here.
	reg         enable_q;       // Enable as seen one cycle earlier.
	reg         active;         // Filling in progress.
	reg         trig_done;      // First trigger already taken.
	reg         post_run;       // Center mode post-trigger run active.
	reg  [11:0] center_end;     // Last address of the center run.
	wire [7:0]  set_prev;       // Sample set before the one being written.
	wire [11:0] trig_addr;      // Neutral word of the last completed set.
	reg  [2:0]  slot;           // Word within the current sample set.
	wire [11:0] addr;           // Current write address.
	wire        start_pulse;    // Rising edge of the capture enable.
	wire        word_step;      // One word written this cycle.
	wire        spare_step;     // Spare word inserted this cycle.
	wire        advance;        // Pointer moves this cycle.
	wire [10:0] trig_hits;      // Enabled trigger sources.
	wire        trig_any;       // Any enabled trigger present.
	wire        page_end;       // Last word of a page written.
	wire [3:0]  page_idx;       // Page of the current address.
	wire        fixed_mode;     // Fixed rate capture chosen.
	// restart needs a fresh rising edge
	assign start_pulse = CAPTURE_ENABLE_BIT_IN & ~enable_q;
	assign fixed_mode  = CAPTURE_SOURCE_SELECT_IN;
	// seven channel words, then a spare word
	assign spare_step = active & (slot == `WFCFC_SLOT_LAST);
	assign word_step  = active & SAMPLE_VALID_IN & (slot != `WFCFC_SLOT_LAST);
	assign advance    = word_step | spare_step;
	// page index from address bits above the 128-word page
	assign page_idx   = addr[`WFCFC_PAGE_MSB:`WFCFC_PAGE_LSB];
	assign page_end   = advance & (addr[`WFCFC_PAGE_LSB-1:0] == `WFCFC_PAGE_WORDS);
	// The set index wraps inside the ring, so a trigger in the first set points at the last one.
	assign set_prev   = addr[`WFCFC_PAGE_MSB:3] - 8'h01;
	assign trig_addr  = {1'b1, set_prev, `WFCFC_SLOT_NEUTRAL};
	// =====================================================================
	// Trigger sources
	// bits 9..0 events, bit 10 forced
	// force acts at once, others follow device events
	genvar gi;
	generate
		for (gi = 0; gi < `WFCFC_TRG_FORCE; gi = gi + 1) begin : g_trig
			assign trig_hits[gi] = TRIGGER_ENABLE_MASK_IN[gi] & EVENT_IN[gi];
		end
	endgenerate
	assign trig_hits[`WFCFC_TRG_FORCE] = TRIGGER_ENABLE_MASK_IN[`WFCFC_TRG_FORCE];
	// Every mode but stop-when-full reacts, and only once per capture.
	assign trig_any = (|trig_hits) & active & ~trig_done & (FILL_MODE_FIELD_IN != `WFCFC_MODE_FULL);
	// =====================================================================
	// Address generator
	wfcfc_addr_gen u_addr (
		.clk_in     (CLOCK_IN),
		.reset_n_in (RESET_N_IN),
		.restart_in (start_pulse),
		.advance_in (advance),
		.addr_out   (addr)
	);
	// =====================================================================
	// Fill sequencer
	// Tracks the enable edge, the active state and the set slot counter.
	always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			enable_q   <= 1'b0;
			active     <= 1'b0;
			trig_done  <= 1'b0;
			post_run   <= 1'b0;
			center_end <= `WFCFC_ZERO12;
			slot       <= 3'h0;
		end else begin
			enable_q <= CAPTURE_ENABLE_BIT_IN;
			if (!CAPTURE_ENABLE_BIT_IN) begin
				active    <= 1'b0;
				post_run  <= 1'b0;
				trig_done <= 1'b0;
			end else if (start_pulse) begin
				// mode zero begins at the first word
				// other modes also begin at the first word
				active     <= fixed_mode;
				trig_done  <= 1'b0;
				post_run   <= 1'b0;
				center_end <= `WFCFC_ZERO12;
				slot       <= 3'h0;
			end else if (active) begin
				if (advance) begin
					slot <= slot + 3'h1;
				end
				// stop after the last word in stop-when-full
				if (advance && FILL_MODE_FIELD_IN == `WFCFC_MODE_FULL && addr == `WFCFC_ADDR_LAST) begin
					active <= 1'b0;
				end
				// ring modes overwrite without waiting for the host
				if (trig_any) begin
					trig_done <= 1'b1;
					if (FILL_MODE_FIELD_IN == `WFCFC_MODE_STOP) begin
						active <= 1'b0;
					end
					if (FILL_MODE_FIELD_IN == `WFCFC_MODE_CENTER) begin
						post_run <= 1'b1;
						// Half a ring away from the stored address is one flip of bit 10.
						center_end <= trig_addr ^ {1'b0, `WFCFC_CENTER_WORDS};
					end
				end
				// stop at the stored address plus or minus 1024
				if (post_run && advance && addr == center_end) begin
					active   <= 1'b0;
					post_run <= 1'b0;
				end
			end
		end
	end
	// =====================================================================
	// Memory write port
	// The spare slot is written as zero so the memory stays deterministic.
	always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			MEM_WE_OUT   <= 1'b0;
			MEM_ADDR_OUT <= `WFCFC_ADDR_FIRST;
			MEM_DATA_OUT <= {DATA_W{1'b0}};
		end else begin
			MEM_WE_OUT   <= advance & ~(trig_any & (FILL_MODE_FIELD_IN == `WFCFC_MODE_STOP));
			MEM_ADDR_OUT <= addr;
			MEM_DATA_OUT <= spare_step ? {DATA_W{1'b0}} : SAMPLE_DATA_IN;
		end
	end
	// =====================================================================
	// Page and trigger reports
	// Cleared on disable; hold their last value otherwise.
	always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			LAST_FILLED_PAGE_OUT      <= `WFCFC_ZERO4;
			TRIGGER_ADDRESS_FIELD_OUT <= `WFCFC_ZERO12;
			FILLING_OUT               <= 1'b0;
		end else begin
			FILLING_OUT <= active;
			if (!CAPTURE_ENABLE_BIT_IN) begin
				// disable resets page and trigger address only
				LAST_FILLED_PAGE_OUT      <= `WFCFC_ZERO4;
				TRIGGER_ADDRESS_FIELD_OUT <= `WFCFC_ZERO12;
			end else begin
				if (page_end) begin
					LAST_FILLED_PAGE_OUT <= page_idx;
				end
				// neutral word of the last completed set
				// equals the last filled set in stop mode
				if (trig_any) begin
					TRIGGER_ADDRESS_FIELD_OUT <= trig_addr;
				end
			end
		end
	end
	// =====================================================================
	// Sticky status and interrupt
	// Set wins over a clear in the same cycle so no event is lost.
	reg [2:0] next_status;
	always @* begin
		next_status = EVENT_STATUS_WORD_OUT & ~STATUS_CLEAR_IN;
		// page n full when its last word is written
		// masked page sets the page flag
		if (page_end && PAGE_MASK_IN[page_idx]) begin
			next_status[`WFCFC_ST_PAGE] = 1'b1;
		end
		if (trig_any) begin
			next_status[`WFCFC_ST_TRIG] = 1'b1;
		end
		// stopped flag after the center run ends
		if (active && post_run && advance && addr == center_end) begin
			next_status[`WFCFC_ST_STOP] = 1'b1;
		end
		// Stop-on-trigger also ends the capture at the trigger.
		if (trig_any && FILL_MODE_FIELD_IN == `WFCFC_MODE_STOP) begin
			next_status[`WFCFC_ST_STOP] = 1'b1;
		end
	end
	// sticky flags each gated by their own enable
	always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			EVENT_STATUS_WORD_OUT <= 3'h0;
			EVENT_IRQ_LINE_OUT    <= 1'b0;
		end else begin
			EVENT_STATUS_WORD_OUT <= next_status;
			EVENT_IRQ_LINE_OUT    <= |(next_status & IRQ_ENABLE_IN);
		end
	end
endmodule // wfcfc_top

// ==== test/wfcfc_checker_sva.sv ====
// Concurrent checks on the capture fill control ports.
`timescale 1ns/1ns
module wfcfc_checker #(
	parameter DATA_W = 32
) (
	// Clock, reset and configuration.
	input wire              CLOCK_IN,
	input wire              RESET_N_IN,
	input wire [1:0]        FILL_MODE_FIELD_IN,
	input wire              CAPTURE_ENABLE_BIT_IN,
	input wire [15:0]       PAGE_MASK_IN,
	input wire [2:0]        IRQ_ENABLE_IN,
	input wire [DATA_W-1:0] SAMPLE_DATA_IN,
	// Observed outputs.
	input wire              MEM_WE_OUT,
	input wire [11:0]       MEM_ADDR_OUT,
	input wire [DATA_W-1:0] MEM_DATA_OUT,
	input wire [2:0]        EVENT_STATUS_WORD_OUT,
	input wire [3:0]        LAST_FILLED_PAGE_OUT,
	input wire [11:0]       TRIGGER_ADDRESS_FIELD_OUT,
	input wire              EVENT_IRQ_LINE_OUT
);
	// ====================
	// Write history
	reg         have_prev; // A word was written since enable.
	reg         full_done; // Last word written in mode zero.
	reg  [11:0] prev_addr; // Previous write address.
	wire [11:0] exp_next = (prev_addr == 12'hFFF) ? 12'h800 : prev_addr + 12'h001;
	wire [3:0]  wr_page  = MEM_ADDR_OUT[10:7];
	wire        quiet    = (EVENT_STATUS_WORD_OUT & IRQ_ENABLE_IN) == 3'h0;
	// have_prev and full_done cleared while disabled, because a new capture restarts at the first word.
	always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			have_prev <= 1'b0;
			full_done <= 1'b0;
			prev_addr <= 12'h800;
		end else if (!CAPTURE_ENABLE_BIT_IN) begin
			have_prev <= 1'b0;
			full_done <= 1'b0;
		end else if (MEM_WE_OUT) begin
			have_prev <= 1'b1;
			full_done <= (FILL_MODE_FIELD_IN == 2'h0) && (MEM_ADDR_OUT == 12'hFFF);
			prev_addr <= MEM_ADDR_OUT;
		end
	end
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// ====================
	// Properties
	a_first_word: assert property (MEM_WE_OUT && !have_prev |-> MEM_ADDR_OUT == 12'h800)
		else $error("first write not at start");
	a_ring_step: assert property (MEM_WE_OUT && have_prev |-> MEM_ADDR_OUT == exp_next)
		else $error("write address out of step");
	a_spare_zero: assert property (MEM_WE_OUT && MEM_ADDR_OUT[2:0] == 3'h7 |-> MEM_DATA_OUT == '0)
		else $error("spare word carries data");
	a_data_carried: assert property (MEM_WE_OUT && MEM_ADDR_OUT[2:0] != 3'h7 |-> MEM_DATA_OUT == $past(SAMPLE_DATA_IN))
		else $error("written word differs");
	a_full_stops: assert property (full_done |-> !MEM_WE_OUT)
		else $error("write after full");
	a_page_flag: assert property (MEM_WE_OUT && MEM_ADDR_OUT[6:0] == 7'h7F && PAGE_MASK_IN[wr_page] |-> ##[1:2] EVENT_STATUS_WORD_OUT[0])
		else $error("page flag missing");
	a_last_page: assert property ((MEM_WE_OUT && MEM_ADDR_OUT[6:0] == 7'h7F) ##1 CAPTURE_ENABLE_BIT_IN [*2] |-> LAST_FILLED_PAGE_OUT == $past(wr_page, 2))
		else $error("last page wrong");
	a_disable_clears: assert property (!CAPTURE_ENABLE_BIT_IN [*2] |-> LAST_FILLED_PAGE_OUT == 4'h0 && TRIGGER_ADDRESS_FIELD_OUT == 12'h000)
		else $error("report not cleared");
	a_irq_quiet: assert property ((quiet && $stable(IRQ_ENABLE_IN)) [*2] |-> !EVENT_IRQ_LINE_OUT)
		else $error("irq without enabled flag");
	a_trig_halts: assert property ($rose(EVENT_STATUS_WORD_OUT[1]) && FILL_MODE_FIELD_IN == 2'h1 |-> ##8 !MEM_WE_OUT [*8])
		else $error("write after trigger");
	c_full_stop: cover property (full_done);
	c_ring_wrap: cover property (MEM_WE_OUT && have_prev && prev_addr == 12'hFFF);
	c_center_end: cover property ($rose(EVENT_STATUS_WORD_OUT[2]));
endmodule // wfcfc_checker
bind wfcfc_top wfcfc_checker #(.DATA_W(DATA_W)) u_wfcfc_checker (.CLOCK_IN, .RESET_N_IN, .FILL_MODE_FIELD_IN,
	.CAPTURE_ENABLE_BIT_IN, .PAGE_MASK_IN, .IRQ_ENABLE_IN, .SAMPLE_DATA_IN, .MEM_WE_OUT, .MEM_ADDR_OUT,
	.MEM_DATA_OUT, .EVENT_STATUS_WORD_OUT, .LAST_FILLED_PAGE_OUT, .TRIGGER_ADDRESS_FIELD_OUT, .EVENT_IRQ_LINE_OUT);

// ==== test/wfcfc_sample_src.sv ====
// Sample stream model: seven channel words per set, then an idle slot.
`timescale 1ns/1ns
module wfcfc_sample_src (
	// Clock, reset and run request.
	input  wire        clk_in,
	input  wire        reset_n_in,
	input  wire        run_in,
	// Channel word stream.
	output reg         valid_out,
	output reg  [31:0] data_out
);
	reg [2:0] slot; // Word position within the set.
	// Data moves every cycle, so an idle word never repeats a sample.
	// seven words, one spare
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slot <= 3'h0;
			valid_out <= 1'b0;
			data_out <= 32'h0000_0000;
		end else begin
			slot <= run_in ? slot + 3'h1 : 3'h0;
			valid_out <= run_in && (slot != 3'h7);
			data_out <= data_out + 32'h0001_0001;
		end
	end
endmodule // wfcfc_sample_src

// ==== test/waveform_capture_fill_control_test.sv ====
// Testbench of the waveform capture fill control.
`timescale 1ns/1ns
module waveform_capture_fill_control_test;
	reg         clk, rst_n, en, run;
	reg  [1:0]  mode;
	reg  [15:0] tmask, pmask;
	reg  [2:0]  irq_en, clr;
	reg  [9:0]  ev;
	wire        sv, we, fill, irq;
	wire [31:0] sd, md;
	wire [2:0]  st;
	wire [3:0]  lp;
	wire [11:0] addr, ta;
	integer     n_mismatch, check_count, n_wr, wraps, cycles, w, k, i;
	reg  [11:0] last_addr, first_addr, exp_ta;
	wfcfc_top u_wfcfc_top (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CAPTURE_SOURCE_SELECT_IN(1'b1),
		.FILL_MODE_FIELD_IN(mode), .CAPTURE_ENABLE_BIT_IN(en), .TRIGGER_ENABLE_MASK_IN(tmask),
		.PAGE_MASK_IN(pmask), .IRQ_ENABLE_IN(irq_en), .STATUS_CLEAR_IN(clr), .EVENT_IN(ev),
		.SAMPLE_VALID_IN(sv), .SAMPLE_DATA_IN(sd), .MEM_WE_OUT(we), .MEM_ADDR_OUT(addr),
		.MEM_DATA_OUT(md), .EVENT_STATUS_WORD_OUT(st), .LAST_FILLED_PAGE_OUT(lp),
		.TRIGGER_ADDRESS_FIELD_OUT(ta), .FILLING_OUT(fill), .EVENT_IRQ_LINE_OUT(irq));
	wfcfc_sample_src u_wfcfc_sample_src (.clk_in(clk), .reset_n_in(rst_n), .run_in(run), .valid_out(sv),
		.data_out(sd));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Writes are counted on the falling edge, away from the design's updates.
	always @(negedge clk) begin
		cycles = cycles + 1;
		if (cycles > 20000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test;
		end
		if (we === 1'b1) begin
			if (n_wr == 0) first_addr = addr;
			if (addr === 12'h800 && last_addr === 12'hFFF) wraps = wraps + 1;
			last_addr = addr;
			n_wr = n_wr + 1;
		end
	end
	task cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input ok, input string m);
		begin
			check_count = check_count + 1;
			if (!ok) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t %s", $time, m);
			end
		end
	endtask
	task wait_wr(input integer n);
		for (w = 0; n_wr < n && w < 3000; w = w + 1) cyc(1);
	endtask
	task clear_st;
		begin
			clr <= 3'h7;
			cyc(1);
			clr <= 3'h0;
			cyc(1);
		end
	endtask
	// The stream stops before the enable drops, so no word is in flight.
	task stop_cap;
		begin
			run <= 1'b0;
			cyc(3);
			en <= 1'b0;
			cyc(3);
		end
	endtask
	task start(input [1:0] m, input [15:0] p);
		begin
			stop_cap;
			mode <= m;
			pmask <= p;
			tmask <= 16'h0000;
			n_wr = 0;
			wraps = 0;
			last_addr = 12'h000;
			cyc(2);
			// triggers cleared before the enable rises
			en <= 1'b1;
			cyc(1);
			run <= 1'b1;
		end
	endtask
	task t_full;
		begin
			irq_en <= 3'h0;
			start(2'h0, 16'h8001);
			wait_wr(128);
			cyc(3);
			chk(first_addr === 12'h800 && st[0] === 1'b1 && lp === 4'h0, "page 0");
			chk(irq === 1'b0, "irq masked");
			irq_en <= 3'h1;
			cyc(2);
			chk(irq === 1'b1, "irq off");
			clear_st;
			wait_wr(256);
			cyc(3);
			chk(st[0] === 1'b0 && irq === 1'b0 && lp === 4'h1, "page 1");
			wait_wr(2048);
			cyc(40);
			chk(n_wr === 2048 && last_addr === 12'hFFF, "no stop");
			chk(st[0] === 1'b1 && lp === 4'hF, "page 15");
			stop_cap;
			chk(lp === 4'h0 && ta === 12'h000, "not cleared");
		end
	endtask
	task t_trig;
		begin
			irq_en <= 3'h2;
			for (i = 0; i < 11; i = i + 1) begin
				start(2'h1, 16'h0000);
				wait_wr(48);
				ev <= 10'h3FF;
				cyc(1);
				ev <= 10'h000;
				cyc(20);
				chk(st[1] === 1'b0 && n_wr > 60, "masked event");
				tmask <= 16'h0001 << i;
				if (i < 10) ev <= 10'h001 << i;
				cyc(1);
				ev <= 10'h000;
				cyc(20);
				k = n_wr;
				cyc(20);
				chk(st[1] === 1'b1 && irq === 1'b1 && n_wr === k, "no trigger");
				exp_ta = (last_addr[2:0] === 3'h7) ? {last_addr[11:3], 3'h6} :
					((last_addr[10:3] === 8'h00) ? 12'hFFE : {last_addr[11:3], 3'h6} - 12'h008);
				chk(ta === exp_ta, "trig addr");
				// force bit cleared before the next capture
				tmask <= 16'h0000;
				clear_st;
			end
		end
	endtask
	task t_ring;
		begin
			start(2'h3, 16'h0000);
			wait_wr(2100);
			cyc(2);
			chk(first_addr === 12'h800 && wraps === 1 && fill === 1'b1, "no wrap");
			// last page read while still enabled, then disable
			chk(lp !== 4'h0 && lp === last_addr[10:7] - 4'h1 || lp === last_addr[10:7], "ring page");
			stop_cap;
		end
	endtask
	// triggers armed only after part of the ring is filled
	task t_center;
		begin
			irq_en <= 3'h4;
			start(2'h2, 16'h0000);
			wait_wr(200);
			tmask <= 16'h0400;
			cyc(1400);
			chk(st[2:1] === 2'h3 && irq === 1'b1 && fill === 1'b0, "center flags");
			exp_ta = ta[10] ? ta - 12'h400 : ta + 12'h400;
			chk(last_addr === exp_ta, "center end");
			tmask <= 16'h0000;
			stop_cap;
		end
	endtask
	task end_of_test;
		begin
			$display("mismatches %0d checks %0d", n_mismatch, check_count);
			if (n_mismatch == 0 && check_count > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	initial begin
		rst_n = 1'b0;
		{en, run, mode, tmask, pmask, irq_en, clr, ev, last_addr, first_addr} = '0;
		n_mismatch = 0;
		check_count = 0;
		cycles = 0;
		n_wr = 0;
		wraps = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		t_full;
		t_trig;
		t_ring;
		t_center;
		end_of_test;
	end
endmodule // waveform_capture_fill_control_test
